// >>> ich_pkg.sv
// ingress credit handler threshold registers: constants, types, helpers
// assumes one core clock and 12-bit dword-aligned configuration offsets
// *****************************************************************
// Functional notes
// *****************************************************************
// Functional notes
// - station pool bits 22:20 hold third port extra header pool; 000b none
// - posted register governs VC0 memory write and message requests
// - non-posted governs reads, I/O, config requests; completion their completions
// - payload field 8:3 is credits/8; first port resets to 10h, 128 credits
// - first port posted header bits 13:9 reset to 16h
// - first port completion header resets to 15h
// - high-priority thresholds: payload 15:14, header 17:16, reset 00b
// - bits 20:18 payload pool: 0,16,32,48, top bit set gives 64
// - non-posted payload bits 8:0 reserved at 000h, infinite credit
// - non-posted header resets to 8h on every port
// - second port payload default 10h at eight lanes, 9h at four
// - second port posted header default Dh at eight lanes, 9h at four
// - second port completion header resets to Ch
// - third port posted and completion payload reset to 9h
// - third port posted header resets to 9h
// - third port completion header resets to 8h
package ich_pkg;

  localparam int FLOWS = 9;

  // *****************************************************************
  // register map
  // *****************************************************************
  localparam logic [11:0] POOL_OFS = 12'h940;
  localparam logic [11:0] FLOW_OFS [FLOWS] = '{
    12'ha00, 12'ha04, 12'ha08, 12'ha18, 12'ha1c, 12'ha20, 12'ha30, 12'ha34, 12'ha38};

  // *****************************************************************
  // field layout
  // *****************************************************************
  localparam int PL_LSB   = 3;
  localparam int HD_LSB   = 9;
  localparam int THP_LSB  = 14;
  localparam int THH_LSB  = 16;
  localparam int POOL_LSB = 18;
  localparam int STN_HP_LSB = 20;
  localparam logic [31:0] STN_POOL_MASK = 32'h00ff_ffff;

  // *****************************************************************
  // reset values
  // *****************************************************************
  localparam logic [5:0] FLOW_PL_RST [FLOWS] = '{
    6'h10, 6'h00, 6'h10, 6'h10, 6'h00, 6'h10, 6'h09, 6'h00, 6'h09};
  localparam logic [4:0] FLOW_HD_RST [FLOWS] = '{
    5'h16, 5'h08, 5'h15, 5'h0d, 5'h08, 5'h0c, 5'h09, 5'h08, 5'h08};
  localparam logic [5:0] PB_X8_PL = 6'h10;
  localparam logic [5:0] PB_X4_PL = 6'h09;
  localparam logic [4:0] PB_X8_HD = 5'h0d;
  localparam logic [4:0] PB_X4_HD = 5'h09;
  localparam logic [1:0] THR_RST  = 2'h0;
  localparam logic [2:0] POOL_RST = 3'h0;
  localparam logic [23:0] STN_POOL_RST = 24'h00_0000;
  localparam logic [1:0] SYNC_FILL = 2'h3;

  // threshold codes
  localparam logic [1:0] THR_75 = 2'h0;
  localparam logic [1:0] THR_50 = 2'h1;
  localparam logic [1:0] THR_25 = 2'h2;
  localparam logic [1:0] THR_100 = 2'h3;

  typedef enum logic [1:0] {FLOW_POSTED, FLOW_NONPOSTED, FLOW_COMPLETION} ich_flow_kind_t;

  typedef struct packed {
    logic [2:0] pool;
    logic [1:0] thr_hd;
    logic [1:0] thr_pl;
    logic [4:0] hd;
    logic [5:0] pl;
  } ich_flow_cfg_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } ich_cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    logic [31:0] data;
  } ich_ldr_wr_t;

  function automatic logic [31:0] ich_pack(ich_flow_cfg_t c);
    ich_pack = (32'(c.pl) << PL_LSB) | (32'(c.hd) << HD_LSB) | (32'(c.thr_pl) << THP_LSB)
             | (32'(c.thr_hd) << THH_LSB) | (32'(c.pool) << POOL_LSB);
  endfunction

  function automatic ich_flow_cfg_t ich_unpack(logic [31:0] w, ich_flow_kind_t k);
    ich_unpack.pl     = (k == FLOW_NONPOSTED) ? 6'h00 : w[PL_LSB +: 6];
    ich_unpack.hd     = w[HD_LSB +: 5];
    ich_unpack.thr_pl = w[THP_LSB +: 2];
    ich_unpack.thr_hd = w[THH_LSB +: 2];
    ich_unpack.pool   = w[POOL_LSB +: 3];
  endfunction

  // top code bit saturates at 64 credits
  function automatic logic [6:0] ich_pool_credits(logic [2:0] code);
    ich_pool_credits = code[2] ? 7'h40 : {1'b0, code[1:0], 4'h0};
  endfunction

endpackage

// >>> ich_sync3.sv
// three-stage synchroniser with agreement filter for a strap pin
// assumes the pin is asynchronous to core_clk_i
`timescale 1ns/10ps
module ich_sync3 import ich_pkg::*; (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      valid_o
);
  logic       s1, s2, s3;
  logic [1:0] fill;
  logic       next_level, next_valid;
  logic [1:0] next_fill;

  always_comb begin
    next_fill  = (fill == SYNC_FILL) ? fill : 2'(fill + 2'h1);
    next_level = level_o;
    next_valid = valid_o;
    if (fill == SYNC_FILL && s2 == s3) begin
      next_level = s3;
      next_valid = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      fill <= 2'h0;
      level_o <= 1'b0;
      valid_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      fill <= next_fill;
      level_o <= next_level;
      valid_o <= next_valid;
    end
  end
endmodule

// >>> ich_flow_cell.sv
// one sticky credit threshold register of one flow
// assumes rst_n_i is the power-on reset only
`timescale 1ns/10ps
module ich_flow_cell import ich_pkg::*; #(
  parameter ich_flow_kind_t KIND   = FLOW_POSTED,
  parameter logic [5:0]     PL_RST = 6'h10,
  parameter logic [4:0]     HD_RST = 5'h08
) (
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          wr_en_i,
  input  wire logic [31:0]   wr_mask_i,
  input  wire logic [31:0]   wr_data_i,
  input  wire logic          dflt_load_i,
  input  wire logic [5:0]    dflt_pl_i,
  input  wire logic [4:0]    dflt_hd_i,
  output ich_flow_cfg_t      cfg_o,
  output logic [31:0]        word_o
);
  ich_flow_cfg_t next_cfg;
  logic [31:0]   merged;

  assign word_o = ich_pack(cfg_o);

  always_comb begin
    merged   = (word_o & ~wr_mask_i) | (wr_data_i & wr_mask_i);
    next_cfg = cfg_o;
    if (wr_en_i) begin
      next_cfg = ich_unpack(merged, KIND);
    end else if (dflt_load_i) begin
      next_cfg.pl = dflt_pl_i;
      next_cfg.hd = dflt_hd_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_o <= '{pool: POOL_RST, thr_hd: THR_RST, thr_pl: THR_RST, hd: HD_RST, pl: PL_RST};
    end else begin
      cfg_o <= next_cfg;
    end
  end
endmodule

// >>> ich_credit_regs.sv
// ingress credit threshold register bank of one three-port station
// assumes rst_n_i is power-on reset and hot_rst_n_i any other reset
// assumes cfg and loader requests come from logic on core_clk_i
`timescale 1ns/10ps
module ich_credit_regs import ich_pkg::*; (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   hot_rst_n_i,
  input  wire ich_cfg_req_t           cfg_req_i,
  input  wire ich_ldr_wr_t            ldr_wr_i,
  input  wire logic                   port_b_x4_pin_i,
  output logic                        cfg_ack_o,
  output logic [31:0]                 cfg_rdata_o,
  output ich_flow_cfg_t [FLOWS-1:0]   credit_cfg_o,
  output logic [FLOWS-1:0][6:0]       pool_credits_o,
  output logic [23:0]                 station_pool_o,
  output logic                        port_b_dflt_pending_o
);

  // *****************************************************************
  // request qualification
  // *****************************************************************
  // requests are dropped during a hot reset so sticky state cannot move
  logic          cfg_go;
  logic          cfg_wr;
  logic          ldr_go;
  logic [31:0]   cfg_mask;
  logic          width_x4;
  logic          width_valid;
  logic          pb_load;
  logic [FLOWS-1:0]       flow_wr;
  logic [FLOWS-1:0]       flow_cfg_hit;
  logic [FLOWS-1:0]       flow_ldr_hit;
  logic [31:0]            flow_word [FLOWS];
  logic [31:0]            flow_mask [FLOWS];
  logic [31:0]            flow_data [FLOWS];

  assign cfg_go   = cfg_req_i.valid && hot_rst_n_i;
  assign cfg_wr   = cfg_go && cfg_req_i.write;
  assign ldr_go   = ldr_wr_i.valid && hot_rst_n_i;
  assign cfg_mask = {{8{cfg_req_i.be[3]}}, {8{cfg_req_i.be[2]}},
                     {8{cfg_req_i.be[1]}}, {8{cfg_req_i.be[0]}}};

  // *****************************************************************
  // lane width strap
  // *****************************************************************
  ich_sync3 u_width_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      (port_b_x4_pin_i),
    .level_o    (width_x4),
    .valid_o    (width_valid)
  );

  // *****************************************************************
  // flow registers
  // *****************************************************************
  // flow index modulo 3 picks posted, non-posted, completion
  genvar g;
  generate
    for (g = 0; g < FLOWS; g++) begin : g_flow
      localparam ich_flow_kind_t KIND = ich_flow_kind_t'(g % 3);
      logic [5:0] dflt_pl;
      logic [4:0] dflt_hd;

      assign flow_cfg_hit[g] = cfg_wr && (cfg_req_i.addr[11:2] == FLOW_OFS[g][11:2]);
      assign flow_ldr_hit[g] = ldr_go && (ldr_wr_i.addr[11:2] == FLOW_OFS[g][11:2]);
      assign flow_wr[g]      = flow_cfg_hit[g] || flow_ldr_hit[g];
      // a configuration write beats a loader write to the same word
      assign flow_mask[g]    = flow_cfg_hit[g] ? cfg_mask : 32'hffff_ffff;
      assign flow_data[g]    = flow_cfg_hit[g] ? cfg_req_i.wdata : ldr_wr_i.data;
      assign dflt_pl = width_x4 ? PB_X4_PL : PB_X8_PL;
      assign dflt_hd = (KIND == FLOW_COMPLETION) ? FLOW_HD_RST[g] :
                       (width_x4 ? PB_X4_HD : PB_X8_HD);

      ich_flow_cell #(
        .KIND   (KIND),
        .PL_RST (FLOW_PL_RST[g]),
        .HD_RST (FLOW_HD_RST[g])
      ) u_cell (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .wr_en_i     (flow_wr[g]),
        .wr_mask_i   (flow_mask[g]),
        .wr_data_i   (flow_data[g]),
        .dflt_load_i (pb_load && (g == 3 || g == 5)),
        .dflt_pl_i   (dflt_pl),
        .dflt_hd_i   (dflt_hd),
        .cfg_o       (credit_cfg_o[g]),
        .word_o      (flow_word[g])
      );
    end
  endgenerate

  // *****************************************************************
  // second port width defaults
  // *****************************************************************
  // applied once, when the strap has settled; a software value wins
  logic next_pending;

  assign pb_load = port_b_dflt_pending_o && width_valid && hot_rst_n_i;

  always_comb begin
    next_pending = port_b_dflt_pending_o;
    if (flow_wr[3] || flow_wr[5] || pb_load) begin
      next_pending = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      port_b_dflt_pending_o <= 1'b1;
    end else begin
      port_b_dflt_pending_o <= next_pending;
    end
  end

  // *****************************************************************
  // station pool register
  // *****************************************************************
  // spare bits 19 and 23 are stored as written; software keeps them zero
  logic        pool_cfg_hit;
  logic        pool_ldr_hit;
  logic [23:0] next_pool;
  logic [31:0] pool_mask;
  logic [31:0] pool_data;

  assign pool_cfg_hit = cfg_wr && (cfg_req_i.addr[11:2] == POOL_OFS[11:2]);
  assign pool_ldr_hit = ldr_go && (ldr_wr_i.addr[11:2] == POOL_OFS[11:2]);

  always_comb begin
    pool_mask = (pool_cfg_hit ? cfg_mask : 32'hffff_ffff) & STN_POOL_MASK;
    pool_data = pool_cfg_hit ? cfg_req_i.wdata : ldr_wr_i.data;
    next_pool = station_pool_o;
    if (pool_cfg_hit || pool_ldr_hit) begin
      next_pool = station_pool_o & ~pool_mask[23:0] | pool_data[23:0] & pool_mask[23:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      station_pool_o <= STN_POOL_RST;
    end else begin
      station_pool_o <= next_pool;
    end
  end

  // *****************************************************************
  // payload pool decode
  // *****************************************************************
  logic [FLOWS-1:0][6:0] next_pool_cr;

  always_comb begin
    for (int i = 0; i < FLOWS; i++) begin
      next_pool_cr[i] = ich_pool_credits(credit_cfg_o[i].pool);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pool_credits_o <= '0;
    end else begin
      pool_credits_o <= next_pool_cr;
    end
  end

  // *****************************************************************
  // read path
  // *****************************************************************
  // unmapped offsets answer with zero; reserved bits read zero
  logic        next_ack;
  logic [31:0] next_rdata;

  always_comb begin
    next_ack   = cfg_go;
    next_rdata = 32'h0000_0000;
    if (cfg_go && !cfg_req_i.write) begin
      for (int i = 0; i < FLOWS; i++) begin
        if (cfg_req_i.addr[11:2] == FLOW_OFS[i][11:2]) begin
          next_rdata = flow_word[i];
        end
      end
      if (cfg_req_i.addr[11:2] == POOL_OFS[11:2]) begin
        next_rdata = {8'h00, station_pool_o};
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !hot_rst_n_i) begin
      cfg_ack_o   <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
    end else begin
      cfg_ack_o   <= next_ack;
      cfg_rdata_o <= next_rdata;
    end
  end

  // *****************************************************************
  // checks
  // *****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking

  req_ack_a: assert property (disable iff (!rst_n_i || !hot_rst_n_i)
    cfg_req_i.valid |=> cfg_ack_o)
    else $error("request not answered next cycle");

  np_payload_zero_a: assert property (disable iff (!rst_n_i)
    credit_cfg_o[1].pl == 6'h00 && credit_cfg_o[4].pl == 6'h00 && credit_cfg_o[7].pl == 6'h00)
    else $error("non-posted payload not zero");

  rsvd_read_a: assert property (disable iff (!rst_n_i || !hot_rst_n_i)
    cfg_ack_o |-> cfg_rdata_o[31:24] == 8'h00)
    else $error("reserved bits read nonzero");

  pool_decode_a: assert property (disable iff (!rst_n_i)
    ##1 pool_credits_o[0] == ($past(credit_cfg_o[0].pool[2]) ? 7'h40 :
        {1'b0, $past(credit_cfg_o[0].pool[1:0]), 4'h0}))
    else $error("pool credits mis-decoded");

  port_a_dflt_a: assert property (disable iff (!hot_rst_n_i)
    $rose(rst_n_i) |-> credit_cfg_o[0].pl == 6'h10 && credit_cfg_o[0].hd == 5'h16 &&
                       credit_cfg_o[2].hd == 5'h15 && credit_cfg_o[1].hd == 5'h08)
    else $error("first port defaults wrong");

  port_c_dflt_a: assert property (disable iff (!hot_rst_n_i)
    $rose(rst_n_i) |-> credit_cfg_o[6].pl == 6'h09 && credit_cfg_o[6].hd == 5'h09 &&
                       credit_cfg_o[8].pl == 6'h09 && credit_cfg_o[8].hd == 5'h08)
    else $error("third port defaults wrong");

  thr_dflt_a: assert property (disable iff (!hot_rst_n_i)
    $rose(rst_n_i) |-> credit_cfg_o[3].thr_pl == 2'h0 && credit_cfg_o[3].thr_hd == 2'h0 &&
                       credit_cfg_o[3].pool == 3'h0 && station_pool_o == 24'h0)
    else $error("threshold or pool default wrong");

  sticky_hot_a: assert property (disable iff (!rst_n_i)
    !hot_rst_n_i |=> $stable(credit_cfg_o) && $stable(station_pool_o))
    else $error("sticky state moved in hot reset");

  pb_x4_load_a: assert property (disable iff (!rst_n_i)
    pb_load && width_x4 && !flow_wr[3] && !flow_wr[5] |=>
      credit_cfg_o[3].pl == 6'h09 && credit_cfg_o[3].hd == 5'h09 && credit_cfg_o[5].pl == 6'h09
      && credit_cfg_o[5].hd == 5'h0c ##1 !port_b_dflt_pending_o[*3])
    else $error("four-lane default not applied");

  pb_x8_load_a: assert property (disable iff (!rst_n_i)
    pb_load && !width_x4 && !flow_wr[3] |=> credit_cfg_o[3].pl == 6'h10 &&
      credit_cfg_o[3].hd == 5'h0d)
    else $error("eight-lane default not applied");

  thr_write_a: assert property (disable iff (!rst_n_i || !hot_rst_n_i)
    cfg_req_i.valid && cfg_req_i.write && cfg_req_i.addr == 12'ha00 && cfg_req_i.be == 4'hf
    |=> credit_cfg_o[0].thr_pl == $past(cfg_req_i.wdata[15:14]) &&
        credit_cfg_o[0].thr_hd == $past(cfg_req_i.wdata[17:16]))
    else $error("threshold write lost");

  hdr_pool_write_a: assert property (disable iff (!rst_n_i || !hot_rst_n_i)
    cfg_req_i.valid && cfg_req_i.write && cfg_req_i.addr == 12'h940 && cfg_req_i.be[2]
    |=> station_pool_o[22:20] == $past(cfg_req_i.wdata[22:20]))
    else $error("header pool write lost");

  // *****************************************************************
  // field and hold checks
  // *****************************************************************

  np_hd_dflt_a: assert property (disable iff (!hot_rst_n_i)
    $rose(rst_n_i) |-> credit_cfg_o[1].hd == 5'h08 &&
      credit_cfg_o[4].hd == 5'h08 && credit_cfg_o[7].hd == 5'h08)
    else $error("non-posted header default wrong");

  pb_hd_dflt_a: assert property (disable iff (!hot_rst_n_i)
    $rose(rst_n_i) |-> credit_cfg_o[5].hd == 5'h0c &&
      credit_cfg_o[3].hd == 5'h0d)
    else $error("second port header default wrong");

  ack_hot_a: assert property (disable iff (!rst_n_i)
    !hot_rst_n_i |=> !cfg_ack_o &&
      cfg_rdata_o == 32'h0000_0000)
    else $error("answer given in hot reset");

  wr_rdata_a: assert property (disable iff (!rst_n_i || !hot_rst_n_i)
    cfg_go && cfg_req_i.write |=>
      cfg_rdata_o == 32'h0000_0000)
    else $error("write answered with data");

  flow_rsvd_a: assert property (disable iff (!rst_n_i || !hot_rst_n_i)
    cfg_go && !cfg_req_i.write &&
      cfg_req_i.addr[11:8] == 4'ha |=>
      cfg_rdata_o[2:0] == 3'h0 &&
      cfg_rdata_o[31:21] == 11'h000)
    else $error("flow reserved bits read nonzero");

  np_rd_zero_a: assert property (disable iff (!rst_n_i || !hot_rst_n_i)
    cfg_go && !cfg_req_i.write &&
      cfg_req_i.addr[11:2] == FLOW_OFS[4][11:2] |=>
      cfg_rdata_o[8:0] == 9'h000)
    else $error("non-posted payload read nonzero");

  ldr_take_a: assert property (disable iff (!rst_n_i)
    ldr_go && !cfg_wr &&
      ldr_wr_i.addr[11:2] == FLOW_OFS[4][11:2] |=>
      credit_cfg_o[4].hd == $past(ldr_wr_i.data[13:9]))
    else $error("loader word lost");

  ldr_pool_a: assert property (disable iff (!rst_n_i)
    ldr_go && !cfg_wr &&
      ldr_wr_i.addr[11:2] == POOL_OFS[11:2] |=>
      station_pool_o == $past(ldr_wr_i.data[23:0]))
    else $error("loader pool word lost");

  pool_hold_a: assert property (disable iff (!rst_n_i)
    !pool_cfg_hit && !pool_ldr_hit |=>
      $stable(station_pool_o))
    else $error("pool word moved unasked");

  flow_hold_a: assert property (disable iff (!rst_n_i)
    !(|flow_wr) && !pb_load |=>
      $stable(credit_cfg_o))
    else $error("flow word moved unasked");

  pend_stay_a: assert property (disable iff (!rst_n_i)
    !port_b_dflt_pending_o |=>
      !port_b_dflt_pending_o)
    else $error("default load armed again");

  pool_sat_a: assert property (disable iff (!rst_n_i)
    credit_cfg_o[6].pool[2] |=>
      pool_credits_o[6] == 7'h40)
    else $error("top pool code not saturated");

  hd_write_a: assert property (disable iff (!rst_n_i || !hot_rst_n_i)
    cfg_wr && cfg_req_i.addr[11:2] == FLOW_OFS[6][11:2] &&
      cfg_req_i.be[1] |=>
      credit_cfg_o[6].hd == $past(cfg_req_i.wdata[13:9]))
    else $error("header write lost");

  pl_write_a: assert property (disable iff (!rst_n_i || !hot_rst_n_i)
    cfg_wr && cfg_req_i.addr[11:2] == FLOW_OFS[6][11:2] &&
      cfg_req_i.be[1] && cfg_req_i.be[0] |=>
      credit_cfg_o[6].pl == $past(cfg_req_i.wdata[8:3]))
    else $error("payload write lost");

  rd_posted_c: cover property (cfg_go && !cfg_req_i.write && cfg_req_i.addr == 12'ha00);
  wr_pool_c: cover property (pool_cfg_hit ##1 cfg_go && !cfg_req_i.write);
  pb_load_c: cover property (pb_load && width_x4);
  hot_rst_c: cover property (rst_n_i && !hot_rst_n_i ##1 hot_rst_n_i);
  ldr_wr_c: cover property (ldr_go && !cfg_wr);

endmodule

// >>> ich_ldr_model.sv
// serial configuration loader model driving full words into the bank
// assumes the bench calls put from its own sequence on core_clk_i
`timescale 1ns/10ps
module ich_ldr_model import ich_pkg::*; (
  input  wire logic  core_clk_i,
  output ich_ldr_wr_t ldr_wr_o
);
  initial begin
    ldr_wr_o = '0;
  end
  // *****
  // one word per call, held over one taken edge
  // *****
  task automatic put(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    #1;
    ldr_wr_o.valid = 1'b1;
    ldr_wr_o.addr  = a;
    ldr_wr_o.data  = (a == POOL_OFS) ? (d & 32'h0077_ffff) : d;
    @(posedge core_clk_i);
    #1;
    ldr_wr_o.valid = 1'b0;
    // released word flips so a stale value is never taken for a live one
    ldr_wr_o.data  = ~ldr_wr_o.data;
  endtask
endmodule

// >>> ich_credit_regs_bench.sv
// self-checking bench for the credit threshold register bank
// assumes the loader model file is compiled before this one
`timescale 1ns/10ps
module ich_credit_regs_bench import ich_pkg::*; ;
  logic                      core_clk_i;
  logic                      rst_n_i;
  logic                      hot_rst_n_i;
  logic                      x4_pin;
  logic                      ack;
  logic                      pend;
  ich_cfg_req_t              req;
  ich_ldr_wr_t               ldr;
  logic [31:0]               rdata;
  ich_flow_cfg_t [FLOWS-1:0] ccfg;
  logic [FLOWS-1:0][6:0]     pcred;
  logic [23:0]               spool;
  int                        num_errors;
  int                        checked;
  logic [15:0]               seed;
  logic [31:0]               mdl [FLOWS];
  logic [31:0]               pmdl;

  ich_credit_regs uut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hot_rst_n_i(hot_rst_n_i),
    .cfg_req_i(req), .ldr_wr_i(ldr), .port_b_x4_pin_i(x4_pin),
    .cfg_ack_o(ack), .cfg_rdata_o(rdata), .credit_cfg_o(ccfg),
    .pool_credits_o(pcred), .station_pool_o(spool), .port_b_dflt_pending_o(pend));
  ich_ldr_model ldrm (.core_clk_i(core_clk_i), .ldr_wr_o(ldr));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // *****
  // expectations
  // *****
  function automatic logic [15:0] lfsr(logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // non-posted payload never writable
  function automatic logic [31:0] wmask(int i);
    wmask = (i % 3 == 1) ? 32'h001f_fe00 : 32'h001f_fff8;
  endfunction
  function automatic logic [31:0] bemask(logic [3:0] be);
    bemask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction
  function automatic logic [6:0] pool_dec(logic [2:0] c);
    pool_dec = c[2] ? 7'h40 : 7'({c[1:0], 4'h0});
  endfunction
  task automatic load_dflt(input logic x4);
    logic [5:0] pl [FLOWS];
    logic [4:0] hd [FLOWS];
    pl = '{6'h10, 6'h00, 6'h10, 6'h10, 6'h00, 6'h10, 6'h09, 6'h00, 6'h09};
    hd = '{5'h16, 5'h08, 5'h15, 5'h0d, 5'h08, 5'h0c, 5'h09, 5'h08, 5'h08};
    if (x4) begin
      pl[3] = 6'h09;
      pl[5] = 6'h09;
      hd[3] = 5'h09;
    end
    for (int i = 0; i < FLOWS; i++) begin
      mdl[i] = (32'(pl[i]) << 3) | (32'(hd[i]) << 9);
    end
    pmdl = 32'h0;
  endtask
  task automatic rnd(output logic [31:0] r);
    seed = lfsr(seed);
    r[31:16] = seed;
    seed = lfsr(seed);
    r[15:0] = seed;
  endtask
  // *****
  // compares and bus cycles
  // *****
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk7(input string what, input logic [6:0] exp, input logic [6:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cfg(input logic wr, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk_i);
    #1;
    req = '{valid: 1'b1, write: wr, addr: a, be: be, wdata: d};
    @(posedge core_clk_i);
    #1;
    req.valid = 1'b0;
    chk32("ack", 32'h1, 32'(ack));
    q = rdata;
  endtask
  // negative index selects the station pool word
  task automatic wr(input int i, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    logic [31:0] m;
    m = (i < 0 ? 32'h00ff_ffff : wmask(i)) & bemask(be);
    cfg(1'b1, i < 0 ? POOL_OFS : FLOW_OFS[i], be, d, q);
    chk32("wr_rdata", 32'h0, q);
    if (i < 0) pmdl = (pmdl & ~m) | (d & m);
    else mdl[i] = (mdl[i] & ~m) | (d & m);
  endtask
  task automatic check_one(input int i);
    logic [31:0] q;
    cfg(1'b0, FLOW_OFS[i], 4'hf, 32'h0, q);
    chk32("flow_word", mdl[i], q);
    chk32("flow_out", 32'(mdl[i][20:3]), 32'(ccfg[i]));
    chk7("pool_cred", pool_dec(mdl[i][20:18]), pcred[i]);
  endtask
  task automatic check_all();
    logic [31:0] q;
    for (int i = 0; i < FLOWS; i++) begin
      check_one(i);
    end
    cfg(1'b0, POOL_OFS, 4'hf, 32'h0, q);
    chk32("pool_word", pmdl, q);
    chk32("pool_out", pmdl, 32'(spool));
  endtask
  task automatic por(input logic x4);
    x4_pin = x4;
    rst_n_i = 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    load_dflt(x4);
    // strap filter settles a few edges after release
    for (int n = 0; n < 20 && pend !== 1'b0; n++) begin
      @(posedge core_clk_i);
      #1;
    end
    chk32("pending", 32'h0, 32'(pend));
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // *****
  // watchdog, run needs well under 5000 cycles
  // *****
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
  // *****
  // main sequence
  // *****
  initial begin
    logic [31:0] r;
    logic [31:0] b;
    logic [31:0] q;
    num_errors = 0;
    checked = 0;
    seed = 16'h4c7b;
    rst_n_i = 1'b0;
    hot_rst_n_i = 1'b1;
    x4_pin = 1'b1;
    req = '0;
    por(1'b1);
    check_all();
    $display("test defaults_x4 done");
    wr(0, 4'h0, 32'hffff_ffff);
    for (int k = 0; k < 40; k++) begin
      rnd(r);
      rnd(b);
      // small credits keep the station sums legal
      wr(int'(b[3:0]) % FLOWS, b[7:4], r & 32'hffe7_de7f);
    end
    check_all();
    $display("test random_writes done");
    for (int c = 0; c < 8; c++) begin
      wr(6, 4'hf, (c << 18) | ((c % 4) << 14) | ((3 - c % 4) << 16) | 32'h1248);
      check_one(6);
    end
    $display("test codes done");
    cfg(1'b0, 12'ha0c, 4'hf, 32'h0, q);
    chk32("unmapped", 32'h0, q);
    cfg(1'b1, 12'ha3c, 4'hf, 32'hffff_ffff, q);
    wr(-1, 4'hf, 32'h0077_ffff);
    wr(-1, 4'h4, 32'h0050_0000);
    check_all();
    $display("test pool_unmapped done");
    ldrm.put(FLOW_OFS[4], 32'hffff_ffff);
    mdl[4] = wmask(4);
    ldrm.put(POOL_OFS, 32'h00ff_ffff);
    pmdl = 32'h0077_ffff;
    check_all();
    @(posedge core_clk_i);
    #1;
    hot_rst_n_i = 1'b0;
    req = '{valid: 1'b1, write: 1'b1, addr: FLOW_OFS[0], be: 4'hf, wdata: 32'h0};
    @(posedge core_clk_i);
    #1;
    req.valid = 1'b0;
    chk32("hot_ack", 32'h0, 32'(ack));
    hot_rst_n_i = 1'b1;
    check_all();
    $display("test loader_hot_reset done");
    por(1'b0);
    check_all();
    $display("test defaults_x8 done");
    summarize();
  end
endmodule
